// ==== core_regs_consts.vh ====
`ifndef CORE_REGS_CONSTS_VH
`define CORE_REGS_CONSTS_VH
// Flag register bit positions
`define FLAG_CARRY      0
`define FLAG_ZERO       1
`define FLAG_NEG        2
`define FLAG_MASK       3
`define FLAG_HALF       4
// Reset values
`define FLAGS_RESET     8'hE8
`define FLAG_BITS_RESET 5'h08
`define FLAGS_ONES      8'hE0
`define WORD_RESET      8'h00
`define PTR_RESET       16'h0000
// Register select codes for the load port
`define SEL_ACC         2'h0
`define SEL_IDX1        2'h1
`define SEL_IDX2        2'h2
// Operation codes
`define OP_NONE         4'h0
`define OP_ADD          4'h1
`define OP_ADC          4'h2
`define OP_SUB          4'h3
`define OP_AND          4'h4
`define OP_OR           4'h5
`define OP_XOR          4'h6
`define OP_LOAD         4'h7
`define OP_SHL          4'h8
`define OP_SHR          4'h9
`define OP_ROL          4'hA
`define OP_ROR          4'hB
`define OP_MUL          4'hC
`define OP_BITTEST      4'hD
// Flag control codes
`define FC_NONE         3'h0
`define FC_MASK_CLEAR   3'h1
`define FC_MASK_SET     3'h2
`define FC_CARRY_SET    3'h3
`define FC_CARRY_CLEAR  3'h4
`define FC_INT_ENTRY    3'h5
`define FC_INT_RETURN   3'h6
`define FC_POP          3'h7
// Branch condition codes: low three bits pick the flag, bit 3 inverts
`define BR_INVERT       3
`define BR_HALF         3'h0
`define BR_MASK         3'h1
`define BR_NEG          3'h2
`define BR_ZERO         3'h3
`define BR_CARRY        3'h4
`endif

// ==== mul8x8.v ====
`timescale 1ns/1ps
`default_nettype none
module mul8x8 (
  input  wire        clock,
  input  wire        nrst,
  input  wire        start,
  input  wire [7:0]  opA,
  input  wire [7:0]  opB,
  output reg  [15:0] product_r
);
  // Registered product keeps the multiplier off the flag path
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      product_r <= 16'h0000;
    end else if (start) begin
      product_r <= opA * opB;
    end
  end
endmodule // mul8x8
`default_nettype wire

// ==== cpu_core_registers_and_flags.v ====
// Operation
// - 8-bit accumulator holds operands and results
// - Two 8-bit index registers for addressing
// - Second index register never stacked on interrupts
// - 16-bit instruction pointer, low and high halves
// - Registers reachable only through instruction ports
// - Flags upper bits one, reset 111x1xxx
// - Push and pop transfer the flag register
// - Half carry from bit 3 on add
// - Mask set on entry, blocks maskable interrupts
// - Mask clear, set and return control mask
// - Masked requests stay pending until unmasked
// - Software clear lets pending requests preempt
// - Negative flag copies result bit 7
// - Zero flag set on zero result
// - Carry on overflow, set and clear ops
// - Carry updated by bit test and shifts
// - Branches test every flag both polarities
// - 8x8 multiplier in the datapath
`timescale 1ns/1ps
`default_nettype none
`include "core_regs_consts.vh"
module cpu_core_registers_and_flags (
  input  wire        clock,
  input  wire        nrst,
  input  wire [3:0]  aluOp,
  input  wire [1:0]  destSel,
  input  wire [7:0]  operand,
  input  wire [2:0]  bitIndex,
  input  wire [2:0]  flagCtrl,
  input  wire [7:0]  popFlags,
  input  wire [7:0]  ptrLowIn,
  input  wire [7:0]  ptrHighIn,
  input  wire        ptrLoadLow,
  input  wire        ptrLoadHigh,
  input  wire        ptrStep,
  input  wire [3:0]  branchCond,
  input  wire        branchCheck,
  input  wire        intRequest,
  input  wire        trapRequest,
  output reg  [7:0]  accumulator_r,
  output reg  [7:0]  indexOne_r,
  output reg  [7:0]  indexTwo_r,
  output reg  [7:0]  instruction_pointer_low_r,
  output reg  [7:0]  instruction_pointer_high_r,
  output reg  [7:0]  condition_flags_r,
  output reg  [7:0]  stackFlags_r,
  output reg         branchTaken_r,
  output reg         intTake_r,
  output reg         intPending_r,
  output reg  [15:0] product_r
);
  reg  [4:0]  flagBits_r;
  reg  [4:0]  flagBits_nxt;
  reg  [8:0]  result;
  reg         halfCarry;
  reg         resultFlags;
  reg         carryFlag;
  reg  [7:0]  src;
  wire [15:0] mulOut;
  wire        maskNow;
  wire        mulStart;
  wire        takeNow;
  wire        writeBack;
  wire        wrAcc;
  wire        wrOne;
  wire        wrTwo;

  // Pick the destination register as the first operand
  function [7:0] pick;
    input [1:0] sel;
    input [7:0] a;
    input [7:0] x;
    input [7:0] y;
    begin
      case (sel)
        `SEL_IDX1: pick = x;
        `SEL_IDX2: pick = y;
        default:   pick = a;
      endcase
    end
  endfunction

  // Full flag byte with the constant upper bits
  function [7:0] packFlags;
    input [4:0] f;
    begin
      packFlags = `FLAGS_ONES | {3'h0, f};
    end
  endfunction

  // Carry out of the low nibble, shared by both adds
  function nibbleCarry;
    input [3:0] a;
    input [3:0] b;
    input       ci;
    begin
      nibbleCarry = ({1'b0, a} + {1'b0, b} + {4'h0, ci}) > 5'h0F;
    end
  endfunction

  // Flag picked by a branch code, bit 3 flips the sense
  function flagTest;
    input [3:0] cond;
    input [4:0] f;
    begin
      case (cond[2:0])
        `BR_HALF:  flagTest = f[`FLAG_HALF]  ^ cond[`BR_INVERT];
        `BR_MASK:  flagTest = f[`FLAG_MASK]  ^ cond[`BR_INVERT];
        `BR_NEG:   flagTest = f[`FLAG_NEG]   ^ cond[`BR_INVERT];
        `BR_ZERO:  flagTest = f[`FLAG_ZERO]  ^ cond[`BR_INVERT];
        `BR_CARRY: flagTest = f[`FLAG_CARRY] ^ cond[`BR_INVERT];
        default:   flagTest = 1'b0;
      endcase
    end
  endfunction

  assign maskNow  = flagBits_r[`FLAG_MASK];
  assign mulStart = (aluOp == `OP_MUL);
  assign writeBack = (aluOp != `OP_NONE) && (aluOp != `OP_BITTEST) && (aluOp != `OP_MUL);
  assign wrAcc     = writeBack && (destSel != `SEL_IDX1) && (destSel != `SEL_IDX2);
  assign wrOne     = writeBack && (destSel == `SEL_IDX1);
  assign wrTwo     = writeBack && (destSel == `SEL_IDX2);
  // Pending or fresh request, taken only while unmasked
  assign takeNow   = (intPending_r | intRequest) & ~maskNow & ~intTake_r;

  mul8x8 u_mul (
    .clock     (clock),
    .nrst      (nrst),
    .start     (mulStart),
    .opA       (accumulator_r),
    .opB       (indexOne_r),
    .product_r (mulOut)
  );

  always @* begin
    src         = pick(destSel, accumulator_r, indexOne_r, indexTwo_r);
    result      = 9'h000;
    halfCarry   = flagBits_r[`FLAG_HALF];
    carryFlag   = flagBits_r[`FLAG_CARRY];
    resultFlags = 1'b1;
    case (aluOp)
      `OP_ADD: begin
        result    = {1'b0, src} + {1'b0, operand};
        halfCarry = nibbleCarry(src[3:0], operand[3:0], 1'b0);
        carryFlag = result[8];
      end
      `OP_ADC: begin
        result    = {1'b0, src} + {1'b0, operand} + {8'h00, flagBits_r[`FLAG_CARRY]};
        halfCarry = nibbleCarry(src[3:0], operand[3:0], flagBits_r[`FLAG_CARRY]);
        carryFlag = result[8];
      end
      `OP_SUB: begin
        result    = {1'b0, src} - {1'b0, operand};
        carryFlag = result[8];
      end
      `OP_AND:  result = {1'b0, src & operand};
      `OP_OR:   result = {1'b0, src | operand};
      `OP_XOR:  result = {1'b0, src ^ operand};
      `OP_LOAD: result = {1'b0, operand};
      `OP_SHL: begin
        result    = {1'b0, src[6:0], 1'b0};
        carryFlag = src[7];
      end
      `OP_SHR: begin
        result    = {2'b00, src[7:1]};
        carryFlag = src[0];
      end
      `OP_ROL: begin
        result    = {1'b0, src[6:0], flagBits_r[`FLAG_CARRY]};
        carryFlag = src[7];
      end
      `OP_ROR: begin
        result    = {1'b0, flagBits_r[`FLAG_CARRY], src[7:1]};
        carryFlag = src[0];
      end
      // Bit test copies bit into carry
      `OP_BITTEST: begin
        result      = {1'b0, src};
        carryFlag   = src[bitIndex];
        resultFlags = 1'b0;
      end
      // Product lands later; H and C cleared, N and Z kept
      `OP_MUL: begin
        result      = {1'b0, src};
        halfCarry   = 1'b0;
        carryFlag   = 1'b0;
        resultFlags = 1'b0;
      end
      default: begin
        result      = {1'b0, src};
        resultFlags = 1'b0;
      end
    endcase
  end

  always @* begin
    flagBits_nxt = flagBits_r;
    if (aluOp != `OP_NONE) begin
      flagBits_nxt[`FLAG_HALF]  = halfCarry;
      flagBits_nxt[`FLAG_CARRY] = carryFlag;
    end
    if (resultFlags) begin
      flagBits_nxt[`FLAG_NEG]  = result[7];
      flagBits_nxt[`FLAG_ZERO] = (result[7:0] == 8'h00);
    end
    case (flagCtrl)
      `FC_MASK_CLEAR:  flagBits_nxt[`FLAG_MASK] = 1'b0;
      `FC_MASK_SET:    flagBits_nxt[`FLAG_MASK] = 1'b1;
      `FC_CARRY_SET:   flagBits_nxt[`FLAG_CARRY] = 1'b1;
      `FC_CARRY_CLEAR: flagBits_nxt[`FLAG_CARRY] = 1'b0;
      // Pop and return restore writable flags
      `FC_INT_RETURN:  flagBits_nxt = popFlags[4:0];
      `FC_POP:         flagBits_nxt = popFlags[4:0];
      default:         flagBits_nxt = flagBits_nxt;
    endcase
    if (flagCtrl == `FC_INT_ENTRY || intTake_r) begin
      flagBits_nxt[`FLAG_MASK] = 1'b1;
    end
  end

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      flagBits_r <= `FLAG_BITS_RESET;
    end else begin
      flagBits_r <= flagBits_nxt;
    end
  end

  // Written only by ops, no address decode
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      accumulator_r <= `WORD_RESET;
    end else if (wrAcc) begin
      accumulator_r <= result[7:0];
    end
  end

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      indexOne_r <= `WORD_RESET;
    end else if (wrOne) begin
      indexOne_r <= result[7:0];
    end
  end

  // Index two written by ops only, never stacked
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      indexTwo_r <= `WORD_RESET;
    end else if (wrTwo) begin
      indexTwo_r <= result[7:0];
    end
  end

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      condition_flags_r <= `FLAGS_RESET;
      stackFlags_r      <= `FLAGS_RESET;
    end else begin
      // Upper three bits read as one
      condition_flags_r <= packFlags(flagBits_nxt);
      // Only the flag byte goes to stack, never index two
      // Push image taken before entry sets mask
      stackFlags_r      <= packFlags(flagBits_r);
    end
  end

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      instruction_pointer_low_r <= `WORD_RESET;
    end else if (ptrLoadLow) begin
      instruction_pointer_low_r <= ptrLowIn;
    end else if (ptrStep) begin
      instruction_pointer_low_r <= instruction_pointer_low_r + 8'h01;
    end
  end

  // High half takes the low half's carry
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      instruction_pointer_high_r <= `WORD_RESET;
    end else if (ptrLoadHigh) begin
      instruction_pointer_high_r <= ptrHighIn;
    end else if (ptrStep && instruction_pointer_low_r == 8'hFF) begin
      instruction_pointer_high_r <= instruction_pointer_high_r + 8'h01;
    end
  end

  // Branch on any flag, either polarity
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      branchTaken_r <= 1'b0;
    end else begin
      branchTaken_r <= branchCheck & flagTest(branchCond, flagBits_r);
    end
  end

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      intPending_r <= 1'b0;
    end else begin
      // A fresh request beats the clear of an older one; a direct take is served once
      intPending_r <= intPending_r ? (intRequest | ~takeNow) : (intRequest & ~takeNow);
    end
  end

  // Taken as soon as mask clears
  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      intTake_r <= 1'b0;
    end else begin
      intTake_r <= trapRequest | takeNow;
    end
  end

  always @(posedge clock or negedge nrst) begin
    if (!nrst) begin
      product_r <= 16'h0000;
    end else begin
      product_r <= mulOut;
    end
  end
endmodule // cpu_core_registers_and_flags
`default_nettype wire

// ==== core_regs_checker.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "core_regs_consts.vh"
module core_regs_checker (
  input wire       clock,
  input wire       nrst,
  input wire [3:0] aluOp,
  input wire [1:0] destSel,
  input wire [7:0] operand,
  input wire [2:0] flagCtrl,
  input wire [3:0] branchCond,
  input wire       branchCheck,
  input wire [7:0] accumulator_r,
  input wire [7:0] condition_flags_r,
  input wire       intTake_r,
  input wire       branchTaken_r
);
  default clocking @(posedge clock); endclocking
  default disable iff (!nrst);
  wire [7:0] flags = condition_flags_r;
  wire       idle  = aluOp == `OP_NONE && flagCtrl == `FC_NONE;
  wire       accOp = flagCtrl == `FC_NONE && destSel == `SEL_ACC;
  upper_ones_a: assert property (flags[7:5] == 3'h7)
    else $error("flag upper bits not set");
  half_carry_a: assert property (accOp && aluOp == `OP_ADD |=>
    flags[4] == ($past(accumulator_r[3:0]) + $past(operand[3:0]) > 5'h0F)) else $error("half carry wrong");
  neg_copy_a: assert property (accOp && aluOp == `OP_LOAD |=> flags[2] == accumulator_r[7])
    else $error("negative flag wrong");
  zero_flag_a: assert property (accOp && aluOp == `OP_LOAD |=> flags[1] == (accumulator_r == 8'h00))
    else $error("zero flag wrong");
  carry_set_a: assert property (aluOp == `OP_NONE && flagCtrl == `FC_CARRY_SET |=> flags[0])
    else $error("carry not set");
  entry_mask_a: assert property (intTake_r |=> flags[3])
    else $error("mask not set on entry");
  // Mask is excluded: interrupt entry may set it while no op runs
  flags_hold_a: assert property (idle && !intTake_r |=> $stable({flags[4], flags[2:0]}))
    else $error("result flags changed");
  branch_zero_a: assert property (idle && branchCheck && branchCond[2:0] == `BR_ZERO |=>
    branchTaken_r == ($past(flags[1]) ^ $past(branchCond[3]))) else $error("zero branch wrong");
endmodule // core_regs_checker
bind cpu_core_registers_and_flags core_regs_checker chk_u (.clock, .nrst, .aluOp, .destSel, .operand, .flagCtrl,
  .branchCond, .branchCheck, .accumulator_r, .condition_flags_r, .intTake_r, .branchTaken_r);
`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "core_regs_consts.vh"
module tb;
  logic        clock = 0, nrst = 0, ptrLoadLow = 0, ptrLoadHigh = 0, ptrStep = 0;
  logic        branchCheck = 0, intRequest = 0, trapRequest = 0;
  logic [3:0]  aluOp = 0, o, branchCond = 0;
  logic [1:0]  destSel = 0;
  logic [7:0]  operand = 0, popFlags = 0, ptrLowIn = 0, ptrHighIn = 0, a, v, f;
  logic [2:0]  bitIndex = 0, flagCtrl = 0;
  wire  [7:0]  accumulator_r, indexOne_r, indexTwo_r, condition_flags_r, stackFlags_r;
  wire  [7:0]  instruction_pointer_low_r, instruction_pointer_high_r;
  wire         branchTaken_r, intTake_r, intPending_r;
  wire  [15:0] product_r;
  wire  [7:0]  cf = condition_flags_r;
  int          fail_count = 0, num_checks = 0;
  logic [31:0] seed = 32'h0000D684;
  logic [8:0]  r;
  logic [3:0]  ops [11] = '{`OP_ADD, `OP_ADC, `OP_SUB, `OP_AND, `OP_OR, `OP_XOR, `OP_LOAD,
                            `OP_SHL, `OP_SHR, `OP_ROL, `OP_ROR};
  logic [11:0] corner [4] = '{12'h708, 12'h108, 12'h1F0, 12'h301};
  cpu_core_registers_and_flags dut_u (.clock, .nrst, .aluOp, .destSel, .operand, .bitIndex, .flagCtrl,
    .popFlags, .ptrLowIn, .ptrHighIn, .ptrLoadLow, .ptrLoadHigh, .ptrStep, .branchCond, .branchCheck,
    .intRequest, .trapRequest, .accumulator_r, .indexOne_r, .indexTwo_r, .instruction_pointer_low_r,
    .instruction_pointer_high_r, .condition_flags_r, .stackFlags_r, .branchTaken_r, .intTake_r,
    .intPending_r, .product_r);
  function automatic logic [7:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed[7:0];
  endfunction
  function automatic logic [8:0] alu(logic [3:0] op, logic [7:0] x, logic [7:0] y, logic ci);
    case (op)
      `OP_ADD: return {1'b0, x} + {1'b0, y};
      `OP_ADC: return {1'b0, x} + {1'b0, y} + {8'h00, ci};
      `OP_SUB: return {1'b0, x} - {1'b0, y};
      `OP_AND: return {ci, x & y};
      `OP_OR:  return {ci, x | y};
      `OP_XOR: return {ci, x ^ y};
      `OP_SHL: return {x, 1'b0};
      `OP_SHR: return {x[0], 1'b0, x[7:1]};
      `OP_ROL: return {x, ci};
      `OP_ROR: return {x[0], ci, x[7:1]};
      default: return {ci, y};
    endcase
  endfunction
  task automatic chk(string n, logic [15:0] s, logic [15:0] e);
    num_checks++;
    if (s !== e) begin
      fail_count++;
      $display("ERROR %s expected %h seen %h", n, e, s);
    end
  endtask
  task automatic cyc(logic [3:0] op, logic [1:0] d, logic [7:0] x, logic [2:0] fc);
    aluOp = op;
    destSel = d;
    operand = x;
    flagCtrl = fc;
    @(posedge clock) #1;
    aluOp = `OP_NONE;
    flagCtrl = `FC_NONE;
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  initial forever #50 clock = ~clock;
  initial begin
    repeat (16) @(posedge clock);
    #1 nrst = 1;
    chk("flags", cf, 16'h00E8);
    chk("stack", stackFlags_r, 16'h00E8);
    // Corner cases first: half carry, wrap to zero, borrow
    for (int i = 0; i < 204; i++) begin
      o = i < 4 ? corner[i][11:8] : ops[rnd() % 11];
      v = i < 4 ? corner[i][7:0] : rnd();
      a = accumulator_r;
      f = cf;
      r = alu(o, a, v, f[0]);
      cyc(o, `SEL_ACC, v, `FC_NONE);
      chk("acc", accumulator_r, r[7:0]);
      chk("neg", cf[2], r[7]);
      chk("zero", cf[1], r[7:0] == 8'h00);
      chk("carry", cf[0], r[8]);
      if (o == `OP_ADD || o == `OP_ADC)
        chk("half", cf[4], {1'b0, a[3:0]} + v[3:0] + (o == `OP_ADC && f[0]) > 5'h0F);
    end
    cyc(`OP_LOAD, `SEL_IDX1, 8'h5A, `FC_NONE);
    cyc(`OP_LOAD, `SEL_IDX2, 8'hA5, `FC_NONE);
    cyc(`OP_LOAD, `SEL_ACC, 8'hFF, `FC_NONE);
    cyc(`OP_MUL, `SEL_ACC, 8'h00, `FC_NONE);
    @(posedge clock) #1;
    chk("product", product_r, 16'h59A6);
    chk("index1", indexOne_r, 16'h005A);
    cyc(`OP_NONE, `SEL_ACC, 8'h00, `FC_MASK_CLEAR);
    cyc(`OP_NONE, `SEL_ACC, 8'h00, `FC_INT_ENTRY);
    chk("push image", stackFlags_r[3], 1'b0);
    chk("index2", indexTwo_r, 16'h00A5);
    chk("mask", cf[3], 1'b1);
    for (int k = 0; k < 16; k++) begin
      popFlags = k == 0 ? 8'h00 : k == 1 ? 8'hFF : rnd();
      cyc(`OP_NONE, `SEL_ACC, 8'h00, k[0] ? `FC_POP : `FC_INT_RETURN);
      chk("popped", cf, {3'h7, popFlags[4:0]});
      branchCond = k[3:0];
      branchCheck = 1;
      @(posedge clock) #1;
      branchCheck = 0;
      chk("branch", branchTaken_r, k[2:0] > 3'h4 ? 1'b0 : cf[3'h4 - k[2:0]] ^ k[3]);
    end
    cyc(`OP_NONE, `SEL_ACC, 8'h00, `FC_CARRY_CLEAR);
    chk("carry clear", cf[0], 1'b0);
    cyc(`OP_NONE, `SEL_ACC, 8'h00, `FC_CARRY_SET);
    chk("carry set", cf[0], 1'b1);
    cyc(`OP_LOAD, `SEL_ACC, 8'h5A, `FC_NONE);
    for (int k = 0; k < 8; k++) begin
      bitIndex = k[2:0];
      cyc(`OP_BITTEST, `SEL_ACC, 8'h5A, `FC_NONE);
      chk("bit test", cf[0], k[0] ^ k[2]);
    end
    cyc(`OP_NONE, `SEL_ACC, 8'h00, `FC_MASK_SET);
    intRequest = 1;
    @(posedge clock) #1;
    intRequest = 0;
    repeat (3) begin
      @(posedge clock) #1;
      chk("masked take", intTake_r, 1'b0);
    end
    chk("pending", intPending_r, 1'b1);
    cyc(`OP_NONE, `SEL_ACC, 8'h00, `FC_MASK_CLEAR);
    chk("mask clear", cf[3], 1'b0);
    for (int n = 0; intTake_r !== 1'b1; n++) begin
      if (n == 8) begin
        fail_count++;
        report_and_stop();
      end
      @(posedge clock) #1;
    end
    @(posedge clock) #1;
    chk("entry mask", cf[3], 1'b1);
    chk("pending clear", intPending_r, 1'b0);
    // A pulse taken at once must not be served twice
    cyc(`OP_NONE, `SEL_ACC, 8'h00, `FC_MASK_CLEAR);
    intRequest = 1;
    @(posedge clock) #1;
    intRequest = 0;
    chk("direct take", intTake_r, 1'b1);
    @(posedge clock) #1;
    chk("entry remask", cf[3], 1'b1);
    cyc(`OP_NONE, `SEL_ACC, 8'h00, `FC_MASK_CLEAR);
    repeat (2) begin
      @(posedge clock) #1;
      chk("served once", intTake_r, 1'b0);
    end
    ptrLowIn = 8'hFF;
    ptrHighIn = 8'h12;
    ptrLoadLow = 1;
    ptrLoadHigh = 1;
    @(posedge clock) #1;
    ptrLoadLow = 0;
    ptrLoadHigh = 0;
    ptrStep = 1;
    @(posedge clock) #1;
    ptrStep = 0;
    chk("pointer", {instruction_pointer_high_r, instruction_pointer_low_r}, 16'h1300);
    report_and_stop();
  end
endmodule // tb
`default_nettype wire
